// file: src/pulse_gen_pkg.sv
// Notes on behaviour
// - Counter readable, read-only, resets to zero
// - Trigger loads low width, copies high buffer
// - Low underflow loads buffer, inverts output
// - High underflow inverts; continuous reloads low, refreshes buffer, one-shot loads ffff
// - New widths apply only from next cycle
// - Each phase lasts reload plus one ticks
// - Load after one or two-three cycles
// - Causes: trigger seen, underflow in high
// - Continuous mode repeats pairs forever
// - One-shot gives one pulse per trigger
// - Restart enable lets triggers reload running
// - Four-bit field picks count clock
// - Clock select takes effect at once
// - Mask holds output low, normal polarity
// - Mask holds output high when inverted
// - Edge field selects external trigger edge
// - Software trigger ignores edge field
// - Reserved top control bit reads zero
// - Pulse mode when function field 010
// - Count enable runs; clearing stops, output at the polarity's idle level
// - Software trigger bit starts, reads zero
// - Flags set on events, write zero clears
package pulse_gen_pkg;
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STAT_OFS = 8'h04;
   localparam logic [7:0] LOWR_OFS = 8'h08;
   localparam logic [7:0] HIGHR_OFS = 8'h0c;
   localparam logic [7:0] CNT_OFS = 8'h10;
   localparam int SOFTWARE_TRIGGER_BIT = 0;
   localparam int COUNT_ENABLE_BIT = 1;
   localparam int UDF_BIT = 0;
   localparam int TRG_BIT = 2;
   localparam int UDIE_BIT = 4;
   localparam int TGIE_BIT = 6;
   localparam int CLOCK_SEL_B3_BIT = 8;
   localparam logic [2:0] FN_PULSE = 3'b010;
   localparam logic [15:0] CNT_RESET = 16'h0000;
   localparam logic [15:0] CNT_UNDER = 16'hffff;
   localparam logic [3:0] CK_DIV1 = 4'h0;
   localparam logic [3:0] CK_DIV4 = 4'h1;
   localparam logic [3:0] CK_DIV16 = 4'h2;
   localparam logic [3:0] CK_DIV128 = 4'h3;
   localparam logic [3:0] CK_DIV256 = 4'h4;
   localparam logic [3:0] CK_EXT_RISE = 4'h5;
   localparam logic [3:0] CK_EXT_FALL = 4'h6;
   localparam logic [3:0] CK_EXT_BOTH = 4'h7;
   localparam logic [3:0] CK_DIV512 = 4'h8;
   localparam logic [3:0] CK_DIV1024 = 4'h9;
   localparam logic [3:0] CK_DIV2048 = 4'ha;
   localparam logic [1:0] EDGE_OFF = 2'b00;
   localparam logic [1:0] EDGE_RISE = 2'b01;
   localparam logic [1:0] EDGE_FALL = 2'b10;
   localparam logic [1:0] EDGE_BOTH = 2'b11;
   // Control word layout; reset value is all zero
   typedef struct packed {
      logic rsv15;
      logic [2:0] clock_sel_lo;
      logic restart_enable;
      logic output_mask;
      logic [1:0] trigger_edge_sel;
      logic rsv7;
      logic [2:0] timer_function_select;
      logic output_polarity;
      logic oneshot_select;
      logic count_enable;
      logic software_trigger;
   } timer_control_t;
   localparam timer_control_t CTRL_RESET = '0;
   typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HIGH} phase_t;
endpackage

// file: src/pulse_width_generator_timer.sv
// The AHB-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/100ps
module pulse_width_generator_timer #(
   parameter int AW = 8
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [AW-1:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic trig_in,
   input wire logic ext_clk_in,
   output logic pulse_out,
   output logic irq_req
);
   pulse_gen_pkg::timer_control_t ctrl_q;
   pulse_gen_pkg::phase_t state_q;
   logic clock_sel_b3_q;
   logic [15:0] low_reload_q;
   logic [15:0] high_reload_q;
   logic [15:0] high_buf_q;
   logic [15:0] cnt_q;
   logic udf_flag_q;
   logic trg_flag_q;
   logic udie_q;
   logic tgie_q;
   logic [31:0] hrdata_q;
   logic wr_pend_q;
   logic [7:0] wr_addr_q;
   logic sw_trig_q;
   logic [10:0] pre_q;
   logic [2:0] trg_sync_q;
   logic [2:0] eck_sync_q;

   // Zero-wait slave: every access completes in its first data phase
   wire addr_ok = hsel && hready && htrans[1];
   wire [7:0] addr8 = haddr[7:0];
   wire wr_ctrl = wr_pend_q && (wr_addr_q == pulse_gen_pkg::CTRL_OFS);
   wire wr_stat = wr_pend_q && (wr_addr_q == pulse_gen_pkg::STAT_OFS);
   wire wr_low = wr_pend_q && (wr_addr_q == pulse_gen_pkg::LOWR_OFS);
   wire wr_high = wr_pend_q && (wr_addr_q == pulse_gen_pkg::HIGHR_OFS);
   wire [3:0] cks = {clock_sel_b3_q, ctrl_q.clock_sel_lo};
   wire running = ctrl_q.count_enable;
   wire pulse_mode = running && (ctrl_q.timer_function_select == pulse_gen_pkg::FN_PULSE);

   // Pin edges: bit 0 and 1 synchronise, bit 2 holds the previous level
   wire trg_rise = trg_sync_q[1] && !trg_sync_q[2];
   wire trg_fall = !trg_sync_q[1] && trg_sync_q[2];
   wire eck_rise = eck_sync_q[1] && !eck_sync_q[2];
   wire eck_fall = !eck_sync_q[1] && eck_sync_q[2];
   wire ext_trig = ((ctrl_q.trigger_edge_sel == pulse_gen_pkg::EDGE_RISE) && trg_rise)
      || ((ctrl_q.trigger_edge_sel == pulse_gen_pkg::EDGE_FALL) && trg_fall)
      || ((ctrl_q.trigger_edge_sel == pulse_gen_pkg::EDGE_BOTH) && (trg_rise || trg_fall));
   wire any_trig = sw_trig_q || ext_trig;
   // Busy timer drops triggers unless restart is allowed
   wire trig_ok = pulse_mode && any_trig
      && (state_q == pulse_gen_pkg::ST_IDLE || ctrl_q.restart_enable);

   // Count clock select; prohibited codes never tick
   wire tick = (cks == pulse_gen_pkg::CK_DIV1) ? 1'b1 :
      (cks == pulse_gen_pkg::CK_DIV4) ? &pre_q[1:0] :
      (cks == pulse_gen_pkg::CK_DIV16) ? &pre_q[3:0] :
      (cks == pulse_gen_pkg::CK_DIV128) ? &pre_q[6:0] :
      (cks == pulse_gen_pkg::CK_DIV256) ? &pre_q[7:0] :
      (cks == pulse_gen_pkg::CK_EXT_RISE) ? eck_rise :
      (cks == pulse_gen_pkg::CK_EXT_FALL) ? eck_fall :
      (cks == pulse_gen_pkg::CK_EXT_BOTH) ? (eck_rise || eck_fall) :
      (cks == pulse_gen_pkg::CK_DIV512) ? &pre_q[8:0] :
      (cks == pulse_gen_pkg::CK_DIV1024) ? &pre_q[9:0] :
      (cks == pulse_gen_pkg::CK_DIV2048) ? &pre_q[10:0] : 1'b0;

   wire at_zero = (cnt_q == 16'h0000);
   wire count_step = pulse_mode && tick && !trig_ok && (state_q != pulse_gen_pkg::ST_IDLE);
   wire low_under = count_step && at_zero && (state_q == pulse_gen_pkg::ST_LOW);
   wire high_under = count_step && at_zero && (state_q == pulse_gen_pkg::ST_HIGH);
   wire wave = (state_q == pulse_gen_pkg::ST_HIGH);

   // Read mux, sampled in the address phase so hrdata is a flop
   wire [31:0] ctrl_rd = {16'h0000, 1'b0, ctrl_q.clock_sel_lo, ctrl_q.restart_enable,
      ctrl_q.output_mask, ctrl_q.trigger_edge_sel, 1'b0, ctrl_q.timer_function_select,
      ctrl_q.output_polarity, ctrl_q.oneshot_select, ctrl_q.count_enable, 1'b0};
   wire [31:0] stat_rd = {23'h000000, clock_sel_b3_q, 1'b0, tgie_q, 1'b0, udie_q, 1'b0,
      trg_flag_q, 1'b0, udf_flag_q};
   wire [31:0] rd_mux = (addr8 == pulse_gen_pkg::CTRL_OFS) ? ctrl_rd :
      (addr8 == pulse_gen_pkg::STAT_OFS) ? stat_rd :
      (addr8 == pulse_gen_pkg::LOWR_OFS) ? {16'h0000, low_reload_q} :
      (addr8 == pulse_gen_pkg::HIGHR_OFS) ? {16'h0000, high_reload_q} :
      (addr8 == pulse_gen_pkg::CNT_OFS) ? {16'h0000, cnt_q} : 32'h00000000;

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = hrdata_q;
   // Mask forces the idle level of the chosen polarity
   assign pulse_out = ctrl_q.output_mask ? ctrl_q.output_polarity
      : (wave ^ ctrl_q.output_polarity);
   assign irq_req = (udf_flag_q && udie_q) || (trg_flag_q && tgie_q);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
         hrdata_q <= 32'h00000000;
      end else begin
         wr_pend_q <= addr_ok && hwrite;
         wr_addr_q <= addr8;
         if (addr_ok && !hwrite) begin
            hrdata_q <= rd_mux;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_q <= pulse_gen_pkg::CTRL_RESET;
         clock_sel_b3_q <= 1'b0;
         udie_q <= 1'b0;
         tgie_q <= 1'b0;
         low_reload_q <= 16'h0000;
         high_reload_q <= 16'h0000;
      end else begin
         if (wr_ctrl) begin
            ctrl_q <= pulse_gen_pkg::timer_control_t'(hwdata[15:0]);
            ctrl_q.rsv15 <= 1'b0;
            ctrl_q.rsv7 <= 1'b0;
            ctrl_q.software_trigger <= 1'b0;
         end
         if (wr_stat) begin
            clock_sel_b3_q <= hwdata[pulse_gen_pkg::CLOCK_SEL_B3_BIT];
            udie_q <= hwdata[pulse_gen_pkg::UDIE_BIT];
            tgie_q <= hwdata[pulse_gen_pkg::TGIE_BIT];
         end
         // Writes land at any time; only loads below consume them
         if (wr_low) begin
            low_reload_q <= hwdata[15:0];
         end
         if (wr_high) begin
            high_reload_q <= hwdata[15:0];
         end
      end
   end

   // Software trigger needs count enable set by the same write; the old value is ignored
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sw_trig_q <= 1'b0;
      end else begin
         sw_trig_q <= wr_ctrl && hwdata[pulse_gen_pkg::SOFTWARE_TRIGGER_BIT]
            && hwdata[pulse_gen_pkg::COUNT_ENABLE_BIT];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         trg_sync_q <= 3'b000;
         eck_sync_q <= 3'b000;
         pre_q <= 11'h000;
      end else begin
         trg_sync_q <= {trg_sync_q[1:0], trig_in};
         eck_sync_q <= {eck_sync_q[1:0], ext_clk_in};
         // Free-running prescaler; a select change can cut one period short
         pre_q <= pre_q + 11'h001;
      end
   end

   // Flags: a new event beats a clearing write in the same cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         udf_flag_q <= 1'b0;
         trg_flag_q <= 1'b0;
      end else begin
         if (high_under) begin
            udf_flag_q <= 1'b1;
         end else if (wr_stat && !hwdata[pulse_gen_pkg::UDF_BIT]) begin
            udf_flag_q <= 1'b0;
         end
         if (trig_ok) begin
            trg_flag_q <= 1'b1;
         end else if (wr_stat && !hwdata[pulse_gen_pkg::TRG_BIT]) begin
            trg_flag_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q <= pulse_gen_pkg::ST_IDLE;
         cnt_q <= pulse_gen_pkg::CNT_RESET;
         high_buf_q <= 16'h0000;
      end else if (!pulse_mode) begin
         state_q <= pulse_gen_pkg::ST_IDLE;
      end else if (trig_ok) begin
         state_q <= pulse_gen_pkg::ST_LOW;
         cnt_q <= low_reload_q;
         high_buf_q <= high_reload_q;
      end else if (count_step) begin
         case (state_q)
            pulse_gen_pkg::ST_LOW: begin
               if (at_zero) begin
                  state_q <= pulse_gen_pkg::ST_HIGH;
                  cnt_q <= high_buf_q;
               end else begin
                  cnt_q <= cnt_q - 16'h0001;
               end
            end
            pulse_gen_pkg::ST_HIGH: begin
               if (at_zero && ctrl_q.oneshot_select) begin
                  state_q <= pulse_gen_pkg::ST_IDLE;
                  cnt_q <= pulse_gen_pkg::CNT_UNDER;
               end else if (at_zero) begin
                  state_q <= pulse_gen_pkg::ST_LOW;
                  cnt_q <= low_reload_q;
                  high_buf_q <= high_reload_q;
               end else begin
                  cnt_q <= cnt_q - 16'h0001;
               end
            end
            default: begin
               state_q <= pulse_gen_pkg::ST_IDLE;
            end
         endcase
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   trig_load_a: assert property (trig_ok |=> state_q == pulse_gen_pkg::ST_LOW
      && cnt_q == $past(low_reload_q) && high_buf_q == $past(high_reload_q))
      else $error("trigger did not load low width and buffer");
   sw_latency_a: assert property (wr_ctrl && hwdata[0] && hwdata[1] && pulse_mode
      && state_q == pulse_gen_pkg::ST_IDLE && ctrl_q.timer_function_select
      == hwdata[6:4] |=> ##1 state_q == pulse_gen_pkg::ST_LOW)
      else $error("software trigger load late");
   low_end_a: assert property (low_under |=> state_q == pulse_gen_pkg::ST_HIGH
      && cnt_q == $past(high_buf_q))
      else $error("low underflow did not enter high phase");
   high_end_a: assert property (high_under && !ctrl_q.oneshot_select
      |=> state_q == pulse_gen_pkg::ST_LOW && cnt_q == $past(low_reload_q))
      else $error("high underflow did not reload low width");
   oneshot_stop_a: assert property (high_under && ctrl_q.oneshot_select
      |=> state_q == pulse_gen_pkg::ST_IDLE && pulse_out == ctrl_q.output_polarity)
      else $error("one-shot did not stop");
   mask_level_a: assert property (ctrl_q.output_mask |-> pulse_out
      == ctrl_q.output_polarity)
      else $error("masked output not at idle level");
   stop_low_a: assert property (!running |=> state_q == pulse_gen_pkg::ST_IDLE
      && (ctrl_q.output_mask || pulse_out == ctrl_q.output_polarity))
      else $error("stopped timer still active");
   no_restart_a: assert property (state_q != pulse_gen_pkg::ST_IDLE
      && !ctrl_q.restart_enable && any_trig |-> !trig_ok)
      else $error("busy trigger accepted without restart");
   edge_off_a: assert property (ctrl_q.trigger_edge_sel == pulse_gen_pkg::EDGE_OFF
      |-> !ext_trig)
      else $error("external trigger with edge select off");
   udf_set_a: assert property (high_under |=> udf_flag_q)
      else $error("underflow flag not set");
   rsv_read_a: assert property ($past(addr_ok && !hwrite && addr8
      == pulse_gen_pkg::CTRL_OFS) |-> hrdata_q[15] == 1'b0 && hrdata_q[0] == 1'b0)
      else $error("reserved or trigger bit read nonzero");
endmodule

// file: sim/pin_partner.sv
`timescale 1ns/100ps
module pin_partner (
   input wire logic hclk,
   input wire logic fire,
   input wire logic clk_run,
   output logic trig_in,
   output logic ext_clk_in
);
   logic [1:0] div_q;
   initial begin
      trig_in = 1'b0;
      ext_clk_in = 1'b0;
      div_q = 2'h0;
   end
   // One pin edge per request, so the bench picks the edge by the current level
   always @(posedge hclk) begin
      if (fire) trig_in <= ~trig_in;
      // Count clock stands still outside the clock tests
      if (clk_run) begin
         div_q <= div_q + 2'h1;
         if (div_q == 2'h3) ext_clk_in <= ~ext_clk_in;
      end
   end
endmodule

// file: sim/test_pulse_width_generator_timer.sv
`timescale 1ns/100ps
module test_pulse_width_generator_timer;
   logic hclk, hresetn, hsel, hwrite, fire, clk_run;
   logic [7:0] haddr;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata, rd_v;
   logic hreadyout, hresp, trig_in, ext_clk_in, pulse_out, irq_req;
   int cyc = 0;
   int n_mismatch, num_checks, seed, lw, hw, lw2, hw2, c0, c1, r, f;
   int divs [11] = '{1, 4, 16, 128, 256, 8, 8, 4, 512, 1024, 2048};
   int edges [4] = '{0, 2, 1, 3};
   pulse_width_generator_timer #(.AW(8)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .trig_in(trig_in), .ext_clk_in(ext_clk_in), .pulse_out(pulse_out), .irq_req(irq_req));
   pin_partner pins (.hclk(hclk), .fire(fire), .clk_run(clk_run), .trig_in(trig_in),
      .ext_clk_in(ext_clk_in));
   task give_verdict;
      $display("Checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   // Zero wait states today, but the master still waits on ready
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      hsize <= 3'b010;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd_v = hrdata;
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string m);
      bus(1'b0, a, 32'h0);
      chk(rd_v, e, m);
   endtask
   task automatic wait_lvl(input logic v, input int lim, output int c);
      int k;
      k = 0;
      while (pulse_out !== v && k < lim) begin
         @(posedge hclk);
         #1;
         k++;
      end
      c = (pulse_out === v) ? cyc : -1;
   endtask
   task automatic hold(input logic v, input int n, input string m);
      repeat (n) begin
         @(posedge hclk);
         #1;
         chk(pulse_out, v, m);
      end
   endtask
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   // Watchdog sized well above the expected run length
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc > 40000) begin
         n_mismatch++;
         give_verdict;
      end
   end
   initial begin
      {hresetn, hsel, hwrite, fire, clk_run, haddr, htrans, hsize, hwdata} = '0;
      {n_mismatch, num_checks} = '0;
      seed = 71;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      #1;
      chk(pulse_out, 1'b0, "reset output");
      chk(hreadyout, 1'b1, "ready after reset");
      chk(hresp, 1'b0, "okay response");
      rd(pulse_gen_pkg::CNT_OFS, 32'h0, "counter reset");
      rd(pulse_gen_pkg::STAT_OFS, 32'h0, "status reset");
      wr(pulse_gen_pkg::CTRL_OFS, 32'h000000a1);
      rd(pulse_gen_pkg::CTRL_OFS, 32'h00000020, "control readback");
      rd(8'h14, 32'h0, "unmapped read");
      $display("Registers test done");
      lw = 4 + {$random(seed)} % 6;
      hw = 1 + {$random(seed)} % 6;
      lw2 = 1 + {$random(seed)} % 6;
      hw2 = 3 + {$random(seed)} % 4;
      wr(pulse_gen_pkg::LOWR_OFS, lw);
      wr(pulse_gen_pkg::HIGHR_OFS, hw);
      wr(pulse_gen_pkg::CTRL_OFS, 32'h23);
      c0 = cyc;
      wr(pulse_gen_pkg::LOWR_OFS, lw2);
      wr(pulse_gen_pkg::HIGHR_OFS, hw2);
      wait_lvl(1'b1, 100, r);
      chk(r - c0, lw + 2, "first rise");
      wait_lvl(1'b0, 100, f);
      chk(f - r, hw + 1, "buffered high");
      wait_lvl(1'b1, 100, r);
      chk(r - f, lw2 + 1, "next low");
      wait_lvl(1'b0, 100, f);
      chk(f - r, hw2 + 1, "next high");
      wait_lvl(1'b1, 100, r);
      wr(pulse_gen_pkg::CTRL_OFS, 32'h20);
      hold(1'b0, 3, "stopped output");
      rd(pulse_gen_pkg::STAT_OFS, 32'h5, "event flags");
      wr(pulse_gen_pkg::STAT_OFS, 32'h1);
      chk(irq_req, 1'b0, "irq masked");
      wr(pulse_gen_pkg::STAT_OFS, 32'h11);
      chk(irq_req, 1'b1, "irq raised");
      wr(pulse_gen_pkg::STAT_OFS, 32'h10);
      chk(irq_req, 1'b0, "irq cleared");
      rd(pulse_gen_pkg::STAT_OFS, 32'h10, "flags cleared");
      $display("Continuous test done");
      wr(pulse_gen_pkg::STAT_OFS, 32'h0);
      wr(pulse_gen_pkg::LOWR_OFS, 32'h0);
      wr(pulse_gen_pkg::HIGHR_OFS, 32'h0);
      for (int i = 0; i < 11; i++) begin
         clk_run <= (i >= 5 && i <= 7);
         wr(pulse_gen_pkg::CTRL_OFS, 32'h20);
         wr(pulse_gen_pkg::STAT_OFS, {23'h0, i[3], 8'h00});
         wr(pulse_gen_pkg::CTRL_OFS, {17'h0, i[2:0], 12'h023});
         wait_lvl(1'b1, 5000, r);
         wait_lvl(1'b0, 5000, f);
         chk(f - r, divs[i], "tick period");
      end
      wr(pulse_gen_pkg::CTRL_OFS, 32'h20);
      clk_run <= 1'b0;
      wr(pulse_gen_pkg::STAT_OFS, 32'h0);
      $display("Clock select test done");
      wr(pulse_gen_pkg::LOWR_OFS, 32'h1);
      wr(pulse_gen_pkg::HIGHR_OFS, 32'h1);
      wr(pulse_gen_pkg::CTRL_OFS, 32'h423);
      hold(1'b0, 12, "mask low");
      wr(pulse_gen_pkg::CTRL_OFS, 32'h42b);
      hold(1'b1, 12, "mask high");
      $display("Mask test done");
      wr(pulse_gen_pkg::LOWR_OFS, 32'h2);
      wr(pulse_gen_pkg::HIGHR_OFS, 32'h2);
      for (int e = 0; e < 4; e++) begin
         wr(pulse_gen_pkg::CTRL_OFS, 32'h20);
         wr(pulse_gen_pkg::CTRL_OFS, {22'h0, edges[e][1:0], 8'h26});
         fire <= 1'b1;
         @(posedge hclk);
         fire <= 1'b0;
         #1;
         c0 = cyc;
         wait_lvl(1'b1, 30, r);
         if (edges[e] == 0) begin
            chk(r, -1, "edge field off");
         end else begin
            chk(r - c0 >= 5 && r - c0 <= 6, 1'b1, "external load");
            wait_lvl(1'b0, 30, f);
            chk(f - r, 3, "one-shot high");
            hold(1'b0, 8, "one-shot idle");
            rd(pulse_gen_pkg::CNT_OFS, 32'hffff, "idle count");
         end
      end
      $display("Trigger test done");
      wr(pulse_gen_pkg::LOWR_OFS, 32'd20);
      for (int t = 0; t < 2; t++) begin
         wr(pulse_gen_pkg::CTRL_OFS, 32'h20);
         wr(pulse_gen_pkg::CTRL_OFS, {20'h0, t[0], 11'h027});
         c0 = cyc;
         repeat (6) @(posedge hclk);
         #1;
         wr(pulse_gen_pkg::CTRL_OFS, {20'h0, t[0], 11'h027});
         c1 = cyc;
         wait_lvl(1'b1, 60, r);
         chk(r - ((t == 1) ? c1 : c0), 22, "restart timing");
      end
      $display("Restart test done");
      give_verdict;
   end
endmodule
